/* hdl/swd_regs.svh */
// Purpose: register map, reset values and timing counts of the output watchdog
// Assumes: byte addresses on a 32-bit classic bus, 16-bit registers in low lanes
// Notes:   nonzero watchdog time means the watchdog is active
`ifndef SWD_REGS_SVH
`define SWD_REGS_SVH

`define SWD_ADR_W       12
`define SWD_DIV_OFS     12'h400
`define SWD_LWD_OFS     12'h410
`define SWD_PWD_OFS     12'h420
`define SWD_CTRL_OFS    12'h120
`define SWD_STAT_OFS    12'h130

`define SWD_DIV_RST     16'h09C2
`define SWD_LWD_RST     16'h03E8
`define SWD_PWD_RST     16'h03E8

// control: requested state code in [3:0]
`define SWD_REQ_LSB     0
`define SWD_REQ_MSB     3
// status fields
`define SWD_ST_REFUSED  4
`define SWD_ST_PD_FIRED 5
`define SWD_ST_LI_FIRED 6
`define SWD_ST_COPY     7

`define SWD_CODE_INIT     4'h1
`define SWD_CODE_PRE_RUN  4'h2
`define SWD_CODE_BOOT     4'h3
`define SWD_CODE_SAFE_RUN 4'h4
`define SWD_CODE_RUN      4'h8

// base clock 25 MHz = 40 ns; system clock 8 ns
`define SWD_CLK_NS      8
`define SWD_BASE_NS     40
`define SWD_BASE_CYC    (`SWD_BASE_NS / `SWD_CLK_NS)
`define SWD_TICK_EXTRA  2

`endif

/* hdl/swd_pkg.sv */
// Purpose: shared types of the output watchdog block
// Assumes: nothing
// Notes:   state codes on the bus live in swd_regs.svh
package swd_pkg;
    typedef enum logic [2:0] {
        SWD_INIT,
        SWD_PRE_RUN,
        SWD_SAFE_RUN,
        SWD_RUN,
        SWD_BOOT
    } swd_state_e;
endpackage

/* hdl/swd_prescaler.sv */
// Purpose: shared watchdog tick from the 25 MHz base period
// Assumes: divider value 1..65535
// Notes:   one tick every (div + 2) base periods
`timescale 1ns/10ps
`include "swd_regs.svh"
module swd_prescaler
    import swd_pkg::*;
(
    // system
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // setting
    input  wire logic [15:0] div_i,
    // tick
    output logic             tick_o
);
    localparam logic [2:0] BASE_LAST = 3'(`SWD_BASE_CYC - 1);

    logic [2:0]  base_r;
    logic        base_en;
    logic [16:0] cnt_r;
    logic [16:0] last;

    assign base_en = (base_r == BASE_LAST);
    assign last    = {1'b0, div_i} + 17'(`SWD_TICK_EXTRA - 1);

    // 40 ns base period from the 8 ns clock
    always_ff @(posedge clk_i) begin
        if (rst_i || base_en) begin
            base_r <= 3'h0;
        end else begin
            base_r <= base_r + 3'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r  <= 17'h00000;
            tick_o <= 1'b0;
        end else begin
            tick_o <= 1'b0;
            if (base_en) begin
                if (cnt_r >= last) begin // R7
                    cnt_r  <= 17'h00000;
                    tick_o <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 17'h00001;
                end
            end
        end
    end

    tick_gap_a: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        tick_o |=> !tick_o [*8])
        else $error("watchdog ticks too close");
endmodule

/* hdl/swd_watchdog.sv */
// Purpose: one timeout watchdog counting shared ticks
// Assumes: restart from logic on the same clock
// Notes:   fired stays until the next restart or a zero time
`timescale 1ns/10ps
module swd_watchdog
    import swd_pkg::*;
(
    // system
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // timing
    input  wire logic        tick_i,
    input  wire logic [15:0] time_i,
    // activity
    input  wire logic        restart_i,
    output logic             fired_o
);
    logic [15:0] cnt_r;

    always_ff @(posedge clk_i) begin
        if (rst_i || restart_i || time_i == 16'h0000) begin // R2 R11
            cnt_r   <= 16'h0000;
            fired_o <= 1'b0;
        end else if (tick_i && !fired_o) begin
            cnt_r <= cnt_r + 16'h0001;
            if (cnt_r + 16'h0001 >= time_i) begin // R6
                fired_o <= 1'b1;
            end
        end
    end

    restart_clr_a: assert property (@(posedge clk_i) disable iff (rst_i) // R2
        restart_i |=> !fired_o)
        else $error("fired after restart");

    off_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        time_i == 16'h0000 |=> !fired_o)
        else $error("disabled watchdog fired");
endmodule

/* hdl/swd_top.sv */
// Purpose: output protection with two watchdogs and the slave state machine
// Assumes: exchange strobes and check results come from logic on clk_i
// Notes:   registers on classic wishbone, one wait state per access
`timescale 1ns/10ps
`include "swd_regs.svh"

// Function
// R1: two watchdogs, each 100 ms by default
// R2: only process-data exchange restarts its watchdog
// R3: timeout clears outputs, state kept
// R4: local interface watchdog fires on silence
// R5: one prescaler, separate counts per watchdog
// R6: timeout is count times tick
// R7: tick is prescaler plus two 40 ns
// R8: prescaler resets to 2498, 100 us
// R9: process-data count resets to 1000
// R10: count 0..65535, prescaler 1..65535
// R11: count zero disables process-data watchdog
// R12: master writes settings only when configured
// R13: power-up state blocks mailbox and process data
// R14: master sets mailbox channels in power-up
// R15: power-up to pre-run checks mailbox setup
// R16: pre-run allows mailbox, rejects process data
// R17: master sets data channels in pre-run
// R18: safe-run entry checks, copies inputs first
// R19: safe-run holds outputs safe, traffic allowed
// R20: disabled watchdog lets safe-run drive outputs
// R21: master sends outputs before run request
// R22: run state drives outputs, all traffic
// R23: firmware load only from power-up, file-only
// R24: illegal or failed requests refused, state kept
module swd_top
    import swd_pkg::*;
(
    // system
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // traffic events
    input  wire logic        pd_exchange_i,
    input  wire logic        local_exchange_i,
    // transition checks
    input  wire logic        mbx_cfg_ok_i,
    input  wire logic        pd_cfg_ok_i,
    input  wire logic        dc_cfg_ok_i,
    // output data from the master
    input  wire logic [1:0]  out_data_i,
    // gates and outputs
    output logic             mbx_en_o,
    output logic             file_only_o,
    output logic             pd_en_o,
    output logic             copy_inputs_o,
    output logic [1:0]       dout_o,
    output logic             pd_fired_o,
    output logic             local_fired_o
);
    logic [15:0]  div_r;
    logic [15:0]  lwd_r;
    logic [15:0]  pwd_r;
    logic [3:0]   req_r;
    logic         req_new_r;
    logic         refused_r;
    logic         copy_r;
    logic         out_seen_r;
    swd_state_e   state_r;
    logic         tick;
    logic         pd_fired;
    logic         li_fired;
    logic         bus_req;
    logic         wr;
    logic         pd_ok_xchg;
    logic         drive_ok;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0]  sel);
        merge16 = old;
        if (sel[0]) begin
            merge16[7:0] = d[7:0];
        end
        if (sel[1]) begin
            merge16[15:8] = d[15:8];
        end
    endfunction

    function automatic logic [3:0] st2code(input swd_state_e s);
        case (s)
            SWD_INIT:     st2code = `SWD_CODE_INIT;
            SWD_PRE_RUN:  st2code = `SWD_CODE_PRE_RUN;
            SWD_SAFE_RUN: st2code = `SWD_CODE_SAFE_RUN;
            SWD_RUN:      st2code = `SWD_CODE_RUN;
            SWD_BOOT:     st2code = `SWD_CODE_BOOT;
            default:      st2code = 4'h0;
        endcase
    endfunction

    // shared tick, separate counts
    swd_prescaler u_pre ( // R5
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .div_i  (div_r),
        .tick_o (tick)
    );

    swd_watchdog u_pd_wd ( // R1
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .tick_i    (tick),
        .time_i    (pwd_r),
        .restart_i (pd_ok_xchg),
        .fired_o   (pd_fired)
    );

    swd_watchdog u_li_wd ( // R4
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .tick_i    (tick),
        .time_i    (lwd_r),
        .restart_i (local_exchange_i),
        .fired_o   (li_fired)
    );

    // a rejected exchange is not successful, so it cannot keep the dog quiet
    assign pd_ok_xchg = pd_exchange_i && pd_en_o; // R2
    assign bus_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr         = bus_req && wb_we_i;

    // bus answer, one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (bus_req && !wb_we_i) begin
            case (wb_adr_i)
                `SWD_DIV_OFS:  wb_dat_o <= {16'h0000, div_r};
                `SWD_LWD_OFS:  wb_dat_o <= {16'h0000, lwd_r};
                `SWD_PWD_OFS:  wb_dat_o <= {16'h0000, pwd_r};
                `SWD_CTRL_OFS: wb_dat_o <= {28'h0000000, req_r};
                `SWD_STAT_OFS: wb_dat_o <= {24'h000000, copy_r, li_fired,
                                            pd_fired, refused_r, st2code(state_r)};
                default:       wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    // settings; the master decides whether to load them at start-up
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_r <= `SWD_DIV_RST; // R8
            lwd_r <= `SWD_LWD_RST; // R1
            pwd_r <= `SWD_PWD_RST; // R9
        end else if (wr) begin
            case (wb_adr_i)
                `SWD_DIV_OFS: begin
                    // zero is outside the range, keep the old divider
                    if (merge16(div_r, wb_dat_i, wb_sel_i) != 16'h0000) begin // R10
                        div_r <= merge16(div_r, wb_dat_i, wb_sel_i);
                    end
                end
                `SWD_LWD_OFS: lwd_r <= merge16(lwd_r, wb_dat_i, wb_sel_i);
                `SWD_PWD_OFS: pwd_r <= merge16(pwd_r, wb_dat_i, wb_sel_i); // R10
                default: begin
                end
            endcase
        end
    end

    // state request register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_r     <= `SWD_CODE_INIT;
            req_new_r <= 1'b0;
        end else begin
            req_new_r <= 1'b0;
            if (wr && wb_adr_i == `SWD_CTRL_OFS && wb_sel_i[0]) begin
                req_r     <= wb_dat_i[`SWD_REQ_MSB:`SWD_REQ_LSB];
                req_new_r <= 1'b1;
            end
        end
    end

    // slave state machine
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r   <= SWD_INIT; // R13
            copy_r    <= 1'b0;
            refused_r <= 1'b0;
        end else begin
            if (copy_r) begin
                state_r <= SWD_SAFE_RUN; // R18
                copy_r  <= 1'b0;
            end else if (req_new_r) begin
                refused_r <= 1'b0;
                case (req_r)
                    `SWD_CODE_INIT: begin
                        state_r <= SWD_INIT;
                    end
                    `SWD_CODE_PRE_RUN: begin
                        if (state_r == SWD_INIT && mbx_cfg_ok_i) begin // R15
                            state_r <= SWD_PRE_RUN;
                        end else if (state_r == SWD_SAFE_RUN || state_r == SWD_RUN) begin
                            state_r <= SWD_PRE_RUN;
                        end else if (state_r != SWD_PRE_RUN) begin
                            refused_r <= 1'b1; // R24
                        end
                    end
                    `SWD_CODE_SAFE_RUN: begin
                        if (state_r == SWD_PRE_RUN && pd_cfg_ok_i && dc_cfg_ok_i) begin
                            copy_r <= 1'b1; // R18
                        end else if (state_r == SWD_RUN) begin
                            state_r <= SWD_SAFE_RUN;
                        end else if (state_r != SWD_SAFE_RUN) begin
                            refused_r <= 1'b1; // R24
                        end
                    end
                    `SWD_CODE_RUN: begin
                        if (state_r == SWD_SAFE_RUN && out_seen_r) begin // R21
                            state_r <= SWD_RUN;
                        end else if (state_r != SWD_RUN) begin
                            refused_r <= 1'b1; // R24
                        end
                    end
                    `SWD_CODE_BOOT: begin
                        if (state_r == SWD_INIT) begin // R23
                            state_r <= SWD_BOOT;
                        end else if (state_r != SWD_BOOT) begin
                            refused_r <= 1'b1; // R24
                        end
                    end
                    default: begin
                        refused_r <= 1'b1; // R24
                    end
                endcase
            end
        end
    end

    // output data seen before run may be requested
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_seen_r <= 1'b0;
        end else if (state_r != SWD_SAFE_RUN && state_r != SWD_RUN) begin
            out_seen_r <= 1'b0;
        end else if (pd_ok_xchg) begin
            out_seen_r <= 1'b1; // R21
        end
    end

    // safe-run may drive only with the watchdog switched off
    assign drive_ok = (state_r == SWD_RUN                          // R22
                      || (state_r == SWD_SAFE_RUN && pwd_r == 16'h0000)) // R20
                      && !pd_fired;                                // R3

    // traffic gates and outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mbx_en_o      <= 1'b0;
            file_only_o   <= 1'b0;
            pd_en_o       <= 1'b0;
            copy_inputs_o <= 1'b0;
            dout_o        <= 2'h0;
            pd_fired_o    <= 1'b0;
            local_fired_o <= 1'b0;
        end else begin
            mbx_en_o      <= state_r == SWD_PRE_RUN || state_r == SWD_SAFE_RUN
                             || state_r == SWD_RUN; // R13 R16 R22
            file_only_o   <= state_r == SWD_BOOT; // R23
            pd_en_o       <= state_r == SWD_SAFE_RUN || state_r == SWD_RUN; // R16 R19
            copy_inputs_o <= copy_r; // R18
            dout_o        <= drive_ok ? out_data_i : 2'h0; // R19
            pd_fired_o    <= pd_fired; // R3
            local_fired_o <= li_fired; // R4
        end
    end

    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    init_block_a: assert property (@(posedge clk_i) disable iff (rst_i) // R13
        state_r == SWD_INIT |=> !mbx_en_o && !pd_en_o)
        else $error("traffic allowed in power-up state");

    pd_gate_a: assert property (@(posedge clk_i) disable iff (rst_i) // R16
        state_r == SWD_PRE_RUN |=> mbx_en_o && !pd_en_o)
        else $error("pre-run gates wrong");

    fired_safe_a: assert property (@(posedge clk_i) disable iff (rst_i) // R3
        pd_fired |=> dout_o == 2'h0)
        else $error("outputs driven after timeout");

    fired_state_a: assert property (@(posedge clk_i) disable iff (rst_i) // R3
        $rose(pd_fired) && !req_new_r && !copy_r |=> state_r == $past(state_r))
        else $error("timeout changed state");

    safe_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // R19
        state_r == SWD_SAFE_RUN && pwd_r != 16'h0000 |=> dout_o == 2'h0)
        else $error("safe-run drove outputs");

    run_drive_a: assert property (@(posedge clk_i) disable iff (rst_i) // R22
        state_r == SWD_RUN && !pd_fired |=> dout_o == $past(out_data_i))
        else $error("run state not driving outputs");

    boot_entry_a: assert property (@(posedge clk_i) disable iff (rst_i) // R23
        state_r == SWD_BOOT && $past(state_r) != SWD_BOOT |-> $past(state_r) == SWD_INIT)
        else $error("firmware load not from power-up");

    copy_first_a: assert property (@(posedge clk_i) disable iff (rst_i) // R18
        $rose(copy_inputs_o) |-> state_r == SWD_SAFE_RUN && $past(state_r) == SWD_PRE_RUN)
        else $error("input copy not tied to safe-run entry");

    refuse_keep_a: assert property (@(posedge clk_i) disable iff (rst_i) // R24
        req_new_r && req_r == `SWD_CODE_RUN && state_r == SWD_PRE_RUN
        |=> state_r == SWD_PRE_RUN && refused_r)
        else $error("skipped state accepted");

    run_cov: cover property (@(posedge clk_i) disable iff (rst_i)
        state_r == SWD_RUN);
    fire_cov: cover property (@(posedge clk_i) disable iff (rst_i)
        $rose(pd_fired) && state_r == SWD_RUN);
    refuse_cov: cover property (@(posedge clk_i) disable iff (rst_i)
        $rose(refused_r));
    boot_cov: cover property (@(posedge clk_i) disable iff (rst_i)
        state_r == SWD_BOOT);
endmodule

/* testbench/swd_master_model.sv */
// Purpose: fieldbus master model facing the output watchdog block
// Assumes: check results and exchanges on the device clock
// Notes:   exchanges only while the device opens process data
`timescale 1ns/10ps
module swd_master_model #(
    parameter logic [1:0] OUT_VAL = 2'h1
) (
    // system
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // commands from the bench
    input  wire logic       go_i,
    input  wire logic       cfg_good_i,
    // device side
    input  wire logic       pd_en_i,
    output logic            pd_exchange_o,
    output logic [1:0]      out_data_o,
    output logic            mbx_cfg_ok_o,
    output logic            pd_cfg_ok_o,
    output logic            dc_cfg_ok_o
);
    logic [1:0] cnt_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= 2'h0;
        end else begin
            cnt_r <= cnt_r + 2'h1;
        end
    end

    // one exchange every four clocks, none while data is rejected
    always_ff @(posedge clk_i) begin
        pd_exchange_o <= !rst_i && go_i && pd_en_i && (cnt_r == 2'h3);
    end

    // valid data once process data opens, junk before
    assign out_data_o   = pd_en_i ? OUT_VAL : {2{cnt_r[0]}};
    assign mbx_cfg_ok_o = cfg_good_i;
    assign pd_cfg_ok_o  = cfg_good_i;
    assign dc_cfg_ok_o  = cfg_good_i;
endmodule

/* testbench/swd_top_tb.sv */
// Purpose: self-checking bench of the output watchdog block
// Assumes: classic wishbone, ack one cycle after the request
// Notes:   divider 1 and times of 3 keep watchdog runs short
`timescale 1ns/10ps
`include "swd_regs.svh"
module swd_top_tb;
    // req, state, {cfg rf mbx pd}, {fo cp dout}
    typedef struct packed {
        logic [3:0] req;
        logic [3:0] st;
        logic       cfg;
        logic       rf;
        logic       mbx;
        logic       pd;
        logic       fo;
        logic       cp;
        logic [1:0] dout;
    } swd_row_s;

    // second pass: skip refused in pre-run, bad code, same state, run back to pre-run
    swd_row_s    rows [20] = '{16'h81C0, 16'h2140, 16'h22A0, 16'h4260, 16'h44B4,
                               16'h88B1, 16'h38F1, 16'h1180, 16'h3388, 16'h23C8,
                               16'h1180, 16'h22A0, 16'h82E0, 16'h44B4, 16'h88B1,
                               16'h58F1, 16'h88B1, 16'h22A0, 16'h44B4, 16'h88B1};
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic        local_exchange_i = 1'b0;
    logic        cfg_good = 1'b1;
    logic        mdl_go = 1'b1;
    logic        loc_go = 1'b1;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        pd_exchange_i;
    logic [1:0]  out_data_i;
    logic        mbx_ok;
    logic        pd_ok;
    logic        dc_ok;
    logic        mbx_en_o;
    logic        file_only_o;
    logic        pd_en_o;
    logic        copy_inputs_o;
    logic [1:0]  dout_o;
    logic        pd_fired_o;
    logic        local_fired_o;
    logic [31:0] q;
    swd_row_s    r;
    int          num_errors = 0;
    int          checks = 0;
    int          copies = 0;
    int          tcyc = 0;
    int          c0;
    int          n;

    always #4 clk_i = ~clk_i;

    // local interface traffic every eight clocks while enabled
    always @(posedge clk_i) begin
        tcyc <= tcyc + 1;
        local_exchange_i <= loc_go && (tcyc[2:0] == 3'h0);
        if (copy_inputs_o === 1'b1) begin
            copies <= copies + 1;
        end
    end

    swd_top swd_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .pd_exchange_i(pd_exchange_i), .local_exchange_i(local_exchange_i),
        .mbx_cfg_ok_i(mbx_ok), .pd_cfg_ok_i(pd_ok), .dc_cfg_ok_i(dc_ok),
        .out_data_i(out_data_i), .mbx_en_o(mbx_en_o), .file_only_o(file_only_o),
        .pd_en_o(pd_en_o), .copy_inputs_o(copy_inputs_o), .dout_o(dout_o),
        .pd_fired_o(pd_fired_o), .local_fired_o(local_fired_o));

    swd_master_model swd_master_model_inst (.clk_i(clk_i), .rst_i(rst_i), .go_i(mdl_go),
        .cfg_good_i(cfg_good), .pd_en_i(pd_en_o), .pd_exchange_o(pd_exchange_i),
        .out_data_o(out_data_i), .mbx_cfg_ok_o(mbx_ok), .pd_cfg_ok_o(pd_ok),
        .dc_cfg_ok_o(dc_ok));

    task automatic close_out;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // request held until ack is sampled, then released
    task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
        int k;
        k = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        if (k >= 20) begin
            num_errors++;
            $display("BAD %0t no bus ack", $time);
            close_out();
        end
    endtask

    task automatic chk_reg(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        wb(1'b0, a, 32'h0, d);
        chk_pin(d, exp);
    endtask

    task automatic wait_fire(input logic loc, output int cnt);
        cnt = 0;
        do begin
            @(posedge clk_i);
            cnt++;
        end while ((loc ? local_fired_o : pd_fired_o) !== 1'b1 && cnt < 100);
        if (cnt >= 100) begin
            num_errors++;
            $display("BAD %0t watchdog never fired", $time);
            close_out();
        end
    endtask

    task automatic after_reset;
        @(posedge clk_i);
        chk_pin({mbx_en_o, pd_en_o, file_only_o, dout_o, pd_fired_o, local_fired_o}, 32'h0);
        chk_reg(`SWD_DIV_OFS, 32'h0000_09C2);
        chk_reg(`SWD_PWD_OFS, 32'h0000_03E8);
        chk_reg(`SWD_LWD_OFS, 32'h0000_03E8);
        chk_reg(`SWD_STAT_OFS, 32'h0000_0001);
        chk_reg(12'h7FC, 32'h0);
    endtask

    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        after_reset();
        $display("test reset done");
        for (int i = 0; i < 20; i++) begin
            r = rows[i];
            cfg_good <= r.cfg;
            c0 = copies;
            wb(1'b1, `SWD_CTRL_OFS, {28'h0, r.req}, q);
            repeat (10) @(posedge clk_i);
            chk_reg(`SWD_STAT_OFS, {27'h0, r.rf, r.st});
            chk_pin({mbx_en_o, pd_en_o, file_only_o, dout_o}, {r.mbx, r.pd, r.fo, r.dout});
            chk_pin(copies - c0, {31'h0, r.cp});
        end
        $display("test state table done");
        wb(1'b1, `SWD_DIV_OFS, 32'h1, q);
        wb(1'b1, `SWD_DIV_OFS, 32'h0, q);
        chk_reg(`SWD_DIV_OFS, 32'h1);
        wb(1'b1, `SWD_PWD_OFS, 32'hFFFF, q);
        chk_reg(`SWD_PWD_OFS, 32'h0000_FFFF);
        wb(1'b1, `SWD_PWD_OFS, 32'h3, q);
        wb(1'b1, `SWD_LWD_OFS, 32'h3, q);
        // local traffic keeps running, it must not hold off this one
        @(posedge clk_i);
        mdl_go <= 1'b0;
        wait_fire(1'b0, n);
        chk_pin(n >= 24, 32'h1);
        repeat (3) @(posedge clk_i);
        chk_pin({dout_o, local_fired_o}, 32'h0);
        chk_reg(`SWD_STAT_OFS, 32'h0000_0028);
        mdl_go <= 1'b1;
        repeat (12) @(posedge clk_i);
        chk_pin({pd_fired_o, dout_o}, 32'h1);
        loc_go <= 1'b0;
        wait_fire(1'b1, n);
        chk_pin({n >= 24, pd_fired_o}, 32'h2);
        loc_go <= 1'b1;
        $display("test watchdog done");
        wb(1'b1, `SWD_PWD_OFS, 32'h0, q);
        @(posedge clk_i);
        mdl_go <= 1'b0;
        repeat (100) @(posedge clk_i);
        chk_pin({pd_fired_o, dout_o}, 32'h1);
        wb(1'b1, `SWD_CTRL_OFS, 32'h4, q);
        repeat (10) @(posedge clk_i);
        chk_pin({pd_en_o, dout_o}, 32'h5);
        $display("test disabled watchdog done");
        rst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        after_reset();
        $display("test second reset done");
        close_out();
    end
endmodule
